// [rtl/ddl_top.sv]
// Digital delay-locked loop: phase detector, code unit, delay chain, two clock outputs.
// Assumes pin inputs are asynchronous to mclk_i and far slower than it.
//
// What this block does
// (R1) Phase detector yields a signed cycle count of reference-to-feedback difference.
// (R2) Code unit steps the delay code to shrink the phase detector value.
// (R3) Current delay code is driven on the bus to the slave delay lines.
// (R4) While code freeze is high and the loop reset is not applied, the delay code never changes.
// (R5) Latch input high two cycles captures the delay control bus value.
// (R6) Loop state resets synchronously while the active-low reset input is low.
// (R7) Either clock output can bypass the loop and follow the reference directly.
// (R8) Detector reference is the reference, halved reference, or a chain tap.
// (R9) Detector feedback is the external feedback clock or a chain tap.
// (R10) Primary and secondary outputs each select their own delay tap.
// (R11) Secondary output adds optional 45, 22.5 or 11.25 degree shift.
// (R12) Secondary output can be divided by two or by four.
// (R13) Each output has its own optional duty cycle correction.
// (R14) Lock output is high while the loop stays phase locked.
// (R15) Mismatch output is high when latched bus value differs from current code.
// (R16) Current code leaves on a six-bit Gray-coded bus to other loops.
// (R17) In time reference mode another loop supplies its Gray-coded code.
// (R18) Loops exchange increment indicators through the fabric interface.
// (R19) Gray output changes at most one bit per update, except when the loop reset forces the code back to its reset value.
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`default_nettype none

module ddl_top (
	input  wire logic                        mclk_i,
	input  wire logic                        resetn_i,
	input  wire logic                        reference_clock_in_i,
	input  wire logic                        feedback_clock_in_i,
	input  wire logic                        active_low_reset_n_i,
	input  wire logic                        code_freeze_i,
	input  wire logic                        control_code_latch_i,
	input  wire logic                        increment_flag_in_i,
	input  wire logic [ddl_pkg::CW-1:0]      gray_code_in_i,
	output logic                             primary_clock_out_o,
	output logic                             secondary_clock_out_o,
	output logic                             lock_o,
	output logic                             code_mismatch_flag_o,
	output logic                             increment_flag_out_o,
	output logic      [ddl_pkg::CW-1:0]      gray_code_out_o,
	output logic      [ddl_pkg::CW-1:0]      delay_control_bus_o,
	input  wire logic [ddl_pkg::AXI_AW-1:0]  s_axi_awaddr_i,
	input  wire logic                        s_axi_awvalid_i,
	output logic                             s_axi_awready_o,
	input  wire logic [31:0]                 s_axi_wdata_i,
	input  wire logic [3:0]                  s_axi_wstrb_i,
	input  wire logic                        s_axi_wvalid_i,
	output logic                             s_axi_wready_o,
	output logic      [1:0]                  s_axi_bresp_o,
	output logic                             s_axi_bvalid_o,
	input  wire logic                        s_axi_bready_i,
	input  wire logic [ddl_pkg::AXI_AW-1:0]  s_axi_araddr_i,
	input  wire logic                        s_axi_arvalid_i,
	output logic                             s_axi_arready_o,
	output logic      [31:0]                 s_axi_rdata_o,
	output logic      [1:0]                  s_axi_rresp_o,
	output logic                             s_axi_rvalid_o,
	input  wire logic                        s_axi_rready_i
);
	import ddl_pkg::*;

	localparam logic [PCW-1:0]        ONE_P = 8'h01;
	localparam logic signed [PCW:0]   TOL   = 9'(LOCK_TOL);
	localparam logic [2:0]            LCNT  = 3'(LOCK_CNT);
	localparam logic [PCW:0]          LIMIT = 9'(DEPTH - 1);

	// ********************************************************************
	// Pin synchroniser.
	// ********************************************************************
	logic [SY_W-1:0] sy1_reg;
	logic [SY_W-1:0] sy2_reg;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sy1_reg <= '0;
			sy2_reg <= '0;
		end else begin
			sy1_reg <= {gray_code_in_i, increment_flag_in_i, active_low_reset_n_i,
				control_code_latch_i, code_freeze_i, feedback_clock_in_i, reference_clock_in_i};
			sy2_reg <= sy1_reg;
		end
	end

	logic          ref_s, fb_s, freeze_s, latch_s, active_low_reset_s, inc_in_s;
	logic [CW-1:0] gray_in_s;
	assign ref_s     = sy2_reg[SY_REF];
	assign fb_s      = sy2_reg[SY_FB];
	assign freeze_s  = sy2_reg[SY_FRZ];
	assign latch_s   = sy2_reg[SY_LAT];
	assign active_low_reset_s    = sy2_reg[SY_RST];
	assign inc_in_s  = sy2_reg[SY_INC];
	assign gray_in_s = sy2_reg[SY_GRAY +: CW];

	// ********************************************************************
	// Register file over AXI4-Lite.
	// ********************************************************************
	logic [31:0] config_reg, config_next, taps_reg, taps_next, rdata_reg, rdata_next;
	logic [AXI_AW-1:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0]  wstrb_reg, wstrb_next;
	logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
	logic awready_reg, awready_next, wready_reg, wready_next;
	logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] status_w, wmask;
	logic do_write;

	always_comb begin
		config_next  = config_reg;
		taps_next    = taps_reg;
		awaddr_next  = awaddr_reg;
		wdata_next   = wdata_reg;
		wstrb_next   = wstrb_reg;
		aw_full_next = aw_full_reg;
		w_full_next  = w_full_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rdata_next   = rdata_reg;
		rresp_next   = rresp_reg;
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{wstrb_reg[i]}};
		end
		do_write = aw_full_reg && w_full_reg && !bvalid_reg;
		if (s_axi_awvalid_i && awready_reg) begin
			aw_full_next = 1'b1;
			awaddr_next  = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && wready_reg) begin
			w_full_next = 1'b1;
			wdata_next  = s_axi_wdata_i;
			wstrb_next  = s_axi_wstrb_i;
		end
		if (do_write) begin
			aw_full_next = 1'b0;
			w_full_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = RESP_OKAY;
			if (awaddr_reg == OFF_CONFIG) begin
				config_next = ((config_reg & ~wmask) | (wdata_reg & wmask)) & CONFIG_MASK;
			end else if (awaddr_reg == OFF_TAPS) begin
				taps_next = ((taps_reg & ~wmask) | (wdata_reg & wmask)) & TAPS_MASK;
			end else if (awaddr_reg != OFF_STATUS) begin
				bresp_next = RESP_SLVERR;
			end
		end else if (bvalid_reg && s_axi_bready_i) begin
			bvalid_next = 1'b0;
		end
		if (s_axi_arvalid_i && arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next  = RESP_OKAY;
			if (s_axi_araddr_i == OFF_CONFIG) begin
				rdata_next = config_reg;
			end else if (s_axi_araddr_i == OFF_TAPS) begin
				rdata_next = taps_reg;
			end else if (s_axi_araddr_i == OFF_STATUS) begin
				rdata_next = status_w;
			end else begin
				rdata_next = 32'h0000_0000;
				rresp_next = RESP_SLVERR;
			end
		end else if (rvalid_reg && s_axi_rready_i) begin
			rvalid_next = 1'b0;
		end
		awready_next = !aw_full_next;
		wready_next  = !w_full_next;
		arready_next = !rvalid_next;
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			config_reg  <= CONFIG_RST;
			taps_reg    <= TAPS_RST;
			awaddr_reg  <= '0;
			wdata_reg   <= '0;
			wstrb_reg   <= '0;
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= '0;
			rresp_reg   <= RESP_OKAY;
		end else begin
			config_reg  <= config_next;
			taps_reg    <= taps_next;
			awaddr_reg  <= awaddr_next;
			wdata_reg   <= wdata_next;
			wstrb_reg   <= wstrb_next;
			aw_full_reg <= aw_full_next;
			w_full_reg  <= w_full_next;
			awready_reg <= awready_next;
			wready_reg  <= wready_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end

	// ********************************************************************
	// Delay chain and tap selection.
	// ********************************************************************
	logic [CW-1:0]      code_reg, code_next, latched_reg, latched_next;
	logic [PCW-1:0]     period_reg, period_next, fine_amt;
	logic [CW+2:0]      prod_p, prod_s;
	logic [PCW:0]       sec_sum;
	logic [CW-1:0]      sel_p, sel_s;
	logic [NTAP-1:0]    tap_w;
	logic [1:0]         fine_w, sdiv_w;

	assign fine_w  = config_reg[CFG_FINE_LO +: 2];
	assign sdiv_w  = config_reg[CFG_SDIV_LO +: 2];
	assign prod_p  = (CW+3)'(code_reg) * (CW+3)'(taps_reg[TAP_P_LO +: 3]); // see (R10)
	assign prod_s  = (CW+3)'(code_reg) * (CW+3)'(taps_reg[TAP_S_LO +: 3]); // see (R10)
	assign sel_p   = prod_p[CW+2:3];
	assign fine_amt = (fine_w == 2'h1) ? (period_reg >> 3) :
		(fine_w == 2'h2) ? (period_reg >> 4) : (fine_w == 2'h3) ? (period_reg >> 5) : '0; // see (R11)
	assign sec_sum = (PCW+1)'(prod_s[CW+2:3]) + (PCW+1)'(fine_amt); // see (R11)
	assign sel_s   = (sec_sum > LIMIT) ? LIMIT[CW-1:0] : sec_sum[CW-1:0];

	ddl_delay_chain #(.DEPTH(DEPTH), .NTAP(NTAP), .IW(CW)) u_chain (
		.mclk_i    (mclk_i),
		.resetn_i  (resetn_i),
		.d_i       (ref_s),
		.tap_sel_i ({sel_s, sel_p, taps_reg[TAP_REF_LO +: CW], code_reg}),
		.tap_o     (tap_w)
	);

	// ********************************************************************
	// Phase detector, code unit, lock and latch.
	// ********************************************************************
	logic ref_div_reg, ref_div_next, ref_q_reg, fb_q_reg, ph_valid_reg, ph_valid_next;
	logic ref_ph, fb_ph, ref_edge, fb_edge, ref_s_q_reg;
	logic [PCW-1:0] cnt_reg, cnt_next;
	logic signed [PCW:0] err_reg, err_next;
	logic [2:0] lock_cnt_reg, lock_cnt_next;
	logic lock_reg, lock_next, latch_q_reg, mismatch_reg, mismatch_next, inc_reg, inc_next;
	logic [CW-1:0] gray_reg, gray_next, target;

	assign ref_ph = config_reg[CFG_REF_CHAIN] ? tap_w[1] :
		(config_reg[CFG_REF_DIV] ? ref_div_reg : ref_s); // see (R8)
	assign fb_ph  = config_reg[CFG_FB_CHAIN] ? tap_w[0] : fb_s; // see (R9)
	assign ref_edge = ref_ph && !ref_q_reg;
	assign fb_edge  = fb_ph && !fb_q_reg;
	assign target   = gray2bin(gray_in_s); // see (R17)

	always_comb begin
		ref_div_next  = (ref_s && !ref_s_q_reg) ? !ref_div_reg : ref_div_reg; // see (R8)
		cnt_next      = ref_edge ? '0 : ((cnt_reg == '1) ? cnt_reg : cnt_reg + ONE_P);
		period_next   = ref_edge ? cnt_reg + ONE_P : period_reg;
		ph_valid_next = fb_edge;
		err_next      = err_reg;
		if (fb_edge) begin
			err_next = (cnt_reg <= (period_reg >> 1)) ? $signed({1'b0, cnt_reg}) :
				$signed({1'b0, cnt_reg}) - $signed({1'b0, period_reg}); // see (R1)
		end
		code_next     = code_reg;
		inc_next      = inc_reg;
		lock_cnt_next = lock_cnt_reg;
		lock_next     = lock_reg;
		if (!active_low_reset_s) begin
			code_next     = CODE_RST; // see (R6)
			inc_next      = 1'b0;
			lock_cnt_next = '0;
			lock_next     = 1'b0;
			ph_valid_next = 1'b0;
			err_next      = '0;
		end else if (!freeze_s) begin // see (R4)
			if (config_reg[CFG_TIME_REF]) begin
				if (target > code_reg) begin
					code_next = code_reg + 1'b1; // see (R19)
					inc_next  = 1'b1;
				end else if (target < code_reg) begin
					code_next = code_reg - 1'b1; // see (R19)
					inc_next  = 1'b0;
				end
			end else if (ph_valid_reg) begin
				if (err_reg > 0 && code_reg != '0) begin
					code_next = code_reg - 1'b1; // see (R2)
					inc_next  = 1'b0; // see (R18)
				end else if (err_reg < 0 && code_reg != '1) begin
					code_next = code_reg + 1'b1; // see (R2)
					inc_next  = 1'b1; // see (R18)
				end
			end
		end
		if (active_low_reset_s && ph_valid_reg) begin
			if (err_reg <= TOL && err_reg >= -TOL) begin
				lock_cnt_next = (lock_cnt_reg == LCNT) ? lock_cnt_reg : lock_cnt_reg + 1'b1;
				lock_next     = (lock_cnt_next == LCNT); // see (R14)
			end else begin
				lock_cnt_next = '0;
				lock_next     = 1'b0; // see (R14)
			end
		end
		latched_next = latched_reg;
		if (!active_low_reset_s) begin
			latched_next = CODE_RST;
		end else if (latch_s && latch_q_reg) begin
			latched_next = code_reg; // see (R5)
		end
		mismatch_next = (latched_next != code_next); // see (R15)
		gray_next     = bin2gray(code_next); // see (R16)
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ref_div_reg  <= 1'b0;
			ref_s_q_reg  <= 1'b0;
			ref_q_reg    <= 1'b0;
			fb_q_reg     <= 1'b0;
			cnt_reg      <= '0;
			period_reg   <= '0;
			ph_valid_reg <= 1'b0;
			err_reg      <= '0;
			code_reg     <= CODE_RST;
			inc_reg      <= 1'b0;
			lock_cnt_reg <= '0;
			lock_reg     <= 1'b0;
			latch_q_reg  <= 1'b0;
			latched_reg  <= CODE_RST;
			mismatch_reg <= 1'b0;
			gray_reg     <= bin2gray(CODE_RST);
		end else begin
			ref_div_reg  <= ref_div_next;
			ref_s_q_reg  <= ref_s;
			ref_q_reg    <= ref_ph;
			fb_q_reg     <= fb_ph;
			cnt_reg      <= cnt_next;
			period_reg   <= period_next;
			ph_valid_reg <= ph_valid_next;
			err_reg      <= err_next;
			code_reg     <= code_next;
			inc_reg      <= inc_next;
			lock_cnt_reg <= lock_cnt_next;
			lock_reg     <= lock_next;
			latch_q_reg  <= latch_s;
			latched_reg  <= latched_next;
			mismatch_reg <= mismatch_next;
			gray_reg     <= gray_next;
		end
	end

	assign status_w = {10'h000, latched_reg, 2'h0, code_reg, 5'h00, inc_in_s,
		mismatch_reg, lock_reg};

	// ********************************************************************
	// Output clock shaping: bypass, divider, duty cycle correction.
	// ********************************************************************
	logic [1:0] out_clk_w;

	for (genvar g = 0; g < 2; g++) begin : g_out
		logic src, src_q_reg, dv_q_reg, clk_reg, clk_next, dv, dv_edge, byp, dcc;
		logic [1:0] dcnt_reg, dcnt_next, div_sel;
		logic [PCW+1:0] hcnt_reg, hcnt_next, half;
		assign src     = tap_w[2+g]; // see (R10)
		assign byp     = config_reg[CFG_BYP_P+g];
		assign dcc     = config_reg[CFG_DCC_P+g];
		assign div_sel = (g == 1) ? sdiv_w : 2'h0;
		assign dv      = (div_sel == 2'h1) ? dcnt_reg[0] :
			((div_sel == 2'h2) ? dcnt_reg[1] : src); // see (R12)
		assign dv_edge = dv && !dv_q_reg;
		assign half    = ((PCW+2)'(period_reg) << div_sel) >> 1;
		always_comb begin
			dcnt_next = (src && !src_q_reg) ? dcnt_reg + 1'b1 : dcnt_reg; // see (R12)
			hcnt_next = dv_edge ? ((half == '0) ? '0 : half - 1'b1) :
				((hcnt_reg != '0) ? hcnt_reg - 1'b1 : '0); // see (R13)
			if (byp) begin
				clk_next = ref_s; // see (R7)
			end else if (dcc) begin
				clk_next = dv_edge || (hcnt_reg != '0); // see (R13)
			end else begin
				clk_next = dv;
			end
		end
		always_ff @(posedge mclk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				src_q_reg <= 1'b0;
				dv_q_reg  <= 1'b0;
				dcnt_reg  <= '0;
				hcnt_reg  <= '0;
				clk_reg   <= 1'b0;
			end else begin
				src_q_reg <= src;
				dv_q_reg  <= dv;
				dcnt_reg  <= dcnt_next;
				hcnt_reg  <= hcnt_next;
				clk_reg   <= clk_next;
			end
		end
		assign out_clk_w[g] = clk_reg;
	end

	assign primary_clock_out_o   = out_clk_w[0];
	assign secondary_clock_out_o = out_clk_w[1];
	assign lock_o                = lock_reg;
	assign code_mismatch_flag_o  = mismatch_reg;
	assign increment_flag_out_o  = inc_reg;
	assign gray_code_out_o       = gray_reg;
	assign delay_control_bus_o   = code_reg; // see (R3)
	assign s_axi_awready_o       = awready_reg;
	assign s_axi_wready_o        = wready_reg;
	assign s_axi_bvalid_o        = bvalid_reg;
	assign s_axi_bresp_o         = bresp_reg;
	assign s_axi_arready_o       = arready_reg;
	assign s_axi_rvalid_o        = rvalid_reg;
	assign s_axi_rdata_o         = rdata_reg;
	assign s_axi_rresp_o         = rresp_reg;

	// ********************************************************************
	// Assertions.
	// ********************************************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_latch_two;
		latch_s ##1 latch_s;
	endsequence
	sequence s_lag;
		ph_valid_reg && err_reg > 0 && !freeze_s && active_low_reset_s && !config_reg[CFG_TIME_REF]
			&& code_reg != '0;
	endsequence

	AST_FREEZE: assert property (freeze_s && active_low_reset_s |=> $stable(code_reg)) // see (R4)
		else $error("Code moved while frozen.");
	AST_LATCH: assert property (s_latch_two |=> latched_reg == $past(code_reg)) // see (R5)
		else $error("Latch did not capture the bus.");
	AST_RESET: assert property (!active_low_reset_s |=> code_reg == CODE_RST && !lock_o) // see (R6)
		else $error("Synchronous reset not applied.");
	AST_ALU_DEC: assert property (s_lag |=> code_reg == $past(code_reg) - 1'b1) // see (R2)
		else $error("Code did not step down on lagging feedback.");
	AST_GRAY_STEP: assert property ($past(active_low_reset_s) |-> // see (R19)
		$countones(gray_code_out_o ^ $past(gray_code_out_o)) <= 1)
		else $error("Gray output changed more than one bit.");
	AST_GRAY_OUT: assert property (##1 gray_code_out_o == bin2gray(delay_control_bus_o)) // see (R16)
		else $error("Gray output not equal to the code.");
	AST_MISMATCH: assert property (code_mismatch_flag_o == (latched_reg != delay_control_bus_o)) // see (R15)
		else $error("Mismatch flag wrong.");
	AST_LOCK_LOSS: assert property (ph_valid_reg && active_low_reset_s && (err_reg > TOL || err_reg < -TOL)
		|=> !lock_o) // see (R14)
		else $error("Lock held after a large error.");
	AST_BYPASS: assert property (config_reg[CFG_BYP_P] |=> primary_clock_out_o == $past(ref_s)) // see (R7)
		else $error("Primary bypass did not follow the reference.");

endmodule // ddl_top

`default_nettype wire

// [rtl/ddl_pkg.sv]
// Constants, register map and code helpers of the digital delay-locked loop.
// Assumes one 200 MHz system clock and AXI4-Lite register access with 32-bit data.
`default_nettype none

package ddl_pkg;

	// ********************************************************************
	// Sizes and timing.
	// ********************************************************************
	localparam int CW        = 6;
	localparam int DEPTH     = 64;
	localparam int PCW       = 8;
	localparam int NTAP      = 4;
	localparam int AXI_AW    = 8;
	localparam int LOCK_TOL  = 1;
	localparam int LOCK_CNT  = 4;
	localparam int CLK_MHZ   = 200;

	// ********************************************************************
	// Register offsets, fields and reset values.
	// ********************************************************************
	localparam logic [AXI_AW-1:0] OFF_CONFIG = 8'h00;
	localparam logic [AXI_AW-1:0] OFF_TAPS   = 8'h04;
	localparam logic [AXI_AW-1:0] OFF_STATUS = 8'h08;

	localparam int CFG_REF_DIV   = 0;
	localparam int CFG_REF_CHAIN = 1;
	localparam int CFG_FB_CHAIN  = 2;
	localparam int CFG_TIME_REF  = 3;
	localparam int CFG_DCC_P     = 4;
	localparam int CFG_DCC_S     = 5;
	localparam int CFG_SDIV_LO   = 6;
	localparam int CFG_FINE_LO   = 8;
	localparam int CFG_BYP_P     = 10;
	localparam int CFG_BYP_S     = 11;

	localparam int TAP_P_LO   = 0;
	localparam int TAP_S_LO   = 8;
	localparam int TAP_REF_LO = 16;

	localparam int ST_LOCK     = 0;
	localparam int ST_MISMATCH = 1;
	localparam int ST_INC_IN   = 2;
	localparam int ST_CODE_LO  = 8;
	localparam int ST_LATCH_LO = 16;

	localparam logic [31:0]   CONFIG_RST  = 32'h0000_0000;
	localparam logic [31:0]   TAPS_RST    = 32'h0000_0000;
	localparam logic [31:0]   CONFIG_MASK = 32'h0000_0fff;
	localparam logic [31:0]   TAPS_MASK   = 32'h003f_0707;
	localparam logic [CW-1:0] CODE_RST    = 6'h00;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ********************************************************************
	// Positions in the synchroniser vector of pin inputs.
	// ********************************************************************
	localparam int SY_REF  = 0;
	localparam int SY_FB   = 1;
	localparam int SY_FRZ  = 2;
	localparam int SY_LAT  = 3;
	localparam int SY_RST  = 4;
	localparam int SY_INC  = 5;
	localparam int SY_GRAY = 6;
	localparam int SY_W    = SY_GRAY + CW;

	// ********************************************************************
	// Gray conversions.
	// ********************************************************************
	function automatic logic [CW-1:0] bin2gray(input logic [CW-1:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [CW-1:0] gray2bin(input logic [CW-1:0] g);
		logic [CW-1:0] b;
		b[CW-1] = g[CW-1];
		for (int i = CW - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

endpackage

`default_nettype wire

// [rtl/ddl_delay_chain.sv]
// Sampled tapped delay chain with registered tap outputs.
// Assumes the input is already synchronous to mclk_i; each tap index is in range.
`default_nettype none

module ddl_delay_chain #(
	parameter int DEPTH = ddl_pkg::DEPTH,
	parameter int NTAP  = ddl_pkg::NTAP,
	parameter int IW    = ddl_pkg::CW
) (
	input  wire logic               mclk_i,
	input  wire logic               resetn_i,
	input  wire logic               d_i,
	input  wire logic [NTAP*IW-1:0] tap_sel_i,
	output logic      [NTAP-1:0]    tap_o
);
	import ddl_pkg::*;

	// ********************************************************************
	// Chain and taps.
	// ********************************************************************
	logic [DEPTH-1:0] chain_reg;
	logic [DEPTH-1:0] chain_next;
	logic [NTAP-1:0]  tap_reg;
	logic [NTAP-1:0]  tap_next;

	always_comb begin
		chain_next = {chain_reg[DEPTH-2:0], d_i};
		for (int i = 0; i < NTAP; i++) begin
			tap_next[i] = chain_reg[tap_sel_i[i*IW +: IW]];
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			chain_reg <= '0;
			tap_reg   <= '0;
		end else begin
			chain_reg <= chain_next;
			tap_reg   <= tap_next;
		end
	end

	assign tap_o = tap_reg;

endmodule // ddl_delay_chain

`default_nettype wire

// [verif/ddl_far_end.sv]
// Far-end model: reference source, returned feedback and a neighbouring loop.
// Assumes the bench sets the neighbour's binary code and increment flag.
`default_nettype none
module ddl_far_end (
	input  wire logic [5:0] nb_code_i,
	input  wire logic       nb_inc_i,
	output logic            ref_o,
	output logic            fb_o,
	output logic [5:0]      gray_o,
	output logic            inc_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Clock sources and neighbour bus.
	// ****
	initial begin
		ref_o = 1'b0;
		forever #80 ref_o = ~ref_o;
	end
	assign #30 fb_o = ref_o;
	assign gray_o = nb_code_i ^ (nb_code_i >> 1);
	assign inc_o = nb_inc_i;
endmodule // ddl_far_end
`default_nettype wire

// [verif/tb.sv]
// Testbench: loop scenarios driven over AXI4-Lite and the pins.
// Assumes ddl_top, ddl_far_end and a 200 MHz clock.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ddl_pkg::*;
	// ****
	// Signals, checks and bus tasks.
	// ****
	logic clk = 0, rn = 0, lrn = 0, frz = 0, lat = 0, ninc = 0, av = 0, wv = 0, br = 0;
	logic arv = 0, rr = 0, rf, fb, pco, sco, lck, mis, increment_flag_out, awr, wrd, bv, arr, rv, increment_flag_in, mon = 0;
	logic [5:0] ncode = 0, gin, gout, bus, gprev = 0, b;
	logic [7:0] aw = 0, ar = 0;
	logic [31:0] wd = 0, rd, st;
	logic [1:0] bresp, rresp;
	int n_fail = 0, num_checks = 0, i;
	always #2.5 clk = ~clk;
	task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic lim(int k, int m);
		if (k >= m) begin
			chk("wait", 0, 1);
			complete_run();
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		aw <= a;
		wd <= d;
		av <= 1;
		wv <= 1;
		br <= 1;
		for (i = 0; i < 50 && (av || wv); i++) begin
			@(posedge clk);
			if (awr) av <= 0;
			if (wrd) wv <= 0;
		end
		for (i = 0; i < 50 && bv !== 1'b1; i++) @(posedge clk);
		lim(i, 50);
		chk("bresp", bresp, RESP_OKAY);
	endtask
	task automatic rdst;
		ar <= OFF_STATUS;
		arv <= 1;
		rr <= 1;
		for (i = 0; i < 50 && arv; i++) begin
			@(posedge clk);
			if (arr) arv <= 0;
		end
		for (i = 0; i < 50 && rv !== 1'b1; i++) @(posedge clk);
		lim(i, 50);
		st = rd;
		chk("rresp", rresp, RESP_OKAY);
	endtask
	always @(posedge clk) begin
		if (mon && $countones(gout ^ gprev) > 1) chk("gray step", 1, 0);
		gprev <= gout;
	end
	// ****
	// Scenarios.
	// ****
	task automatic t_lock;
		wr(OFF_TAPS, 32'h000a_0000);
		wr(OFF_CONFIG, 32'h0000_0006);
		mon <= 1;
		lrn <= 1;
		for (i = 0; i < 4000 && lck !== 1'b1; i++) @(posedge clk);
		lim(i, 4000);
		chk("code near", bus >= 6'd9 && bus <= 6'd11, 1);
		lat <= 1;
		repeat (2) @(posedge clk);
		lat <= 0;
		repeat (8) @(posedge clk);
		rdst();
		chk("lock bit", st[ST_LOCK], 1);
		chk("latched", st[21:16], bus);
		chk("mismatch low", mis, 0);
	endtask
	task automatic t_freeze;
		frz <= 1;
		repeat (4) @(posedge clk);
		b = bus;
		wr(OFF_TAPS, 32'h000e_0000);
		repeat (400) @(posedge clk);
		chk("frozen", bus, b);
		frz <= 0;
		repeat (800) @(posedge clk);
		chk("moved up", bus > b, 1);
		chk("mismatch high", mis, 1);
	endtask
	task automatic t_time_ref;
		mon <= 0;
		lrn <= 0;
		repeat (5) @(posedge clk);
		chk("reset code", {lck, gout, bus}, 0);
		wr(OFF_CONFIG, 32'h0000_0008);
		ncode <= 6'd45;
		ninc <= 1;
		lrn <= 1;
		mon <= 1;
		repeat (120) @(posedge clk);
		chk("follow code", bus, 6'd45);
		chk("gray out", gout, 6'h3b);
		chk("inc out", increment_flag_out, 1);
		rdst();
		chk("inc in", st[ST_INC_IN], 1);
	endtask
	task automatic t_bypass;
		wr(OFF_CONFIG, 32'h0000_0c00);
		for (i = 0; i < 80 && rf; i++) @(posedge clk);
		lim(i, 80);
		for (i = 0; i < 80 && !rf; i++) @(posedge clk);
		lim(i, 80);
		repeat (10) @(posedge clk);
		chk("bypass high", {pco, sco}, 2'h3);
		repeat (16) @(posedge clk);
		chk("bypass low", {pco, sco}, 2'h0);
	endtask
	ddl_far_end ddl_far_end_inst (.nb_code_i(ncode), .nb_inc_i(ninc), .ref_o(rf), .fb_o(fb),
		.gray_o(gin), .inc_o(increment_flag_in));
	ddl_top ddl_top_inst (.mclk_i(clk), .resetn_i(rn), .reference_clock_in_i(rf),
		.feedback_clock_in_i(fb), .active_low_reset_n_i(lrn), .code_freeze_i(frz),
		.control_code_latch_i(lat), .increment_flag_in_i(increment_flag_in), .gray_code_in_i(gin),
		.primary_clock_out_o(pco), .secondary_clock_out_o(sco), .lock_o(lck),
		.code_mismatch_flag_o(mis), .increment_flag_out_o(increment_flag_out), .gray_code_out_o(gout),
		.delay_control_bus_o(bus), .s_axi_awaddr_i(aw), .s_axi_awvalid_i(av),
		.s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
		.s_axi_wready_o(wrd), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
		.s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr));
	initial begin
		repeat (3) @(posedge clk);
		rn <= 1;
		@(posedge clk);
		t_lock();
		t_freeze();
		t_time_ref();
		t_bypass();
		complete_run();
	end
endmodule // tb
`default_nettype wire
